// *** src/video_feature_port_control.sv ***
// video feature port direction, data routing and pixel clock pin control
`default_nettype none
module video_feature_port_control
    import vport_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    // configuration
    input  wire logic [2:0]  i_port_mode,
    input  wire logic        i_mode_valid,
    input  wire logic        i_ext_display_clk_sel,
    input  wire logic        i_test_mode,
    input  wire logic        i_pixel_out_ctl,
    input  wire logic [1:0]  i_blank_dpms,
    input  wire logic [1:0]  i_hsync_dpms,
    input  wire logic [1:0]  i_vsync_dpms,
    // host data cycle for vmi / mpeg
    input  wire logic        i_host_write,
    input  wire logic [7:0]  i_host_wdata,
    output logic      [7:0]  o_host_rdata,
    // internal pixel stream
    input  wire logic [15:0] i_int_pixel,
    input  wire logic        i_int_pixel_clk,
    input  wire logic        i_clock_synth_clk,
    // external pins
    input  wire logic        i_ext_port_direction_pin,
    input  wire logic [15:0] i_port_in,
    output logic      [15:0] o_port_out,
    output logic      [1:0]  o_port_oe,
    input  wire logic        i_pclk_pin_in,
    output logic             o_pclk_pin_out,
    output logic             o_pclk_pin_oe,
    input  wire logic        i_ext_video_clk_in,
    output logic             o_blank_oe,
    output logic             o_hsync_oe,
    output logic             o_vsync_oe,
    // towards the ramdac and capture path
    output logic      [15:0] o_ramdac_pixel,
    output logic             o_ramdac_ext_src,
    output logic             o_ramdac_clk_edge,
    output logic      [15:0] o_video_word,
    output logic             o_video_valid,
    output logic             o_mode_reject
);
    // ========================================
    // synchronisers
    logic [2:0] pin_sync;
    logic [2:0] pin_rise;
    logic       dir_s;
    logic       pclk_rise;
    logic       vclk_rise;
    logic [15:0] port_s1_q;
    logic [15:0] port_s2_q;

    vport_sync #(.WIDTH(3)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   ({i_ext_port_direction_pin, i_pclk_pin_in, i_ext_video_clk_in}),
        .o_sync    (pin_sync),
        .o_rise    (pin_rise)
    );
    assign dir_s     = pin_sync[2];
    assign pclk_rise = pin_rise[1];
    assign vclk_rise = pin_rise[0];

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            port_s1_q <= WORD_ZERO;
            port_s2_q <= WORD_ZERO;
        end else begin
            port_s1_q <= i_port_in;
            port_s2_q <= port_s1_q;
        end
    end

    // ========================================
    // mode register
    port_mode_t mode_q;
    logic       reject_q;

    function automatic logic mode_allowed(input port_mode_t m, input logic ext_clk);
        mode_allowed = !ext_clk || (m == MODE_FC8) || (m == MODE_NONE);
    endfunction

    function automatic logic is_fc(input port_mode_t m);
        is_fc = (m == MODE_FC8) || (m == MODE_FC16) || (m == MODE_VAFC);
    endfunction

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_q   <= MODE_NONE;
            reject_q <= 1'b0;
        end else if (i_mode_valid) begin
            if (mode_allowed(port_mode_t'(i_port_mode), i_ext_display_clk_sel)) begin
                mode_q   <= port_mode_t'(i_port_mode);
                reject_q <= 1'b0;
            end else begin
                mode_q   <= MODE_NONE;
                reject_q <= 1'b1;
            end
        end else if (!mode_allowed(mode_q, i_ext_display_clk_sel)) begin
            mode_q   <= MODE_NONE;
            reject_q <= 1'b1;
        end
    end

    // ========================================
    // direction decode
    logic fc_in;
    logic fc_out;
    logic pix_normal;
    assign fc_in      = is_fc(mode_q) && !dir_s;
    assign fc_out     = is_fc(mode_q) && dir_s;
    assign pix_normal = (i_pixel_out_ctl == PIX_OUT_NORMAL);

    // ========================================
    // port drive
    byte_lane_t lo_d;
    byte_lane_t hi_d;
    sync_oe_t   sync_d;

    always_comb begin
        lo_d   = '{din: port_s2_q[7:0], dout: BYTE_ZERO, oe: 1'b0};
        hi_d   = '{din: port_s2_q[15:8], dout: BYTE_ZERO, oe: 1'b0};
        sync_d = '{blank_oe: 1'b0, hsync_oe: 1'b0, vsync_oe: 1'b0};
        case (mode_q)
            MODE_FC8, MODE_FC16, MODE_VAFC: begin
                if (fc_out) begin
                    lo_d.dout = i_int_pixel[7:0];
                    lo_d.oe   = pix_normal;
                    sync_d.blank_oe = (i_blank_dpms != 2'b11);
                    sync_d.hsync_oe = (i_hsync_dpms != 2'b11);
                    sync_d.vsync_oe = (i_vsync_dpms != 2'b11);
                end
                // high byte in fc16 and vafc
                if (fc_out && mode_q != MODE_FC8) begin
                    hi_d.dout = i_int_pixel[15:8];
                    hi_d.oe   = pix_normal;
                end
            end
            MODE_VMI: begin
                hi_d.dout = i_host_wdata;
                hi_d.oe   = i_host_write;
            end
            MODE_MPEG: begin
                hi_d.dout = i_host_wdata;
                hi_d.oe   = i_host_write;
                sync_d.hsync_oe = 1'b1;
                sync_d.vsync_oe = 1'b1;
            end
            MODE_VDEC: begin
                sync_d.hsync_oe = 1'b1;
                sync_d.vsync_oe = 1'b1;
            end
            default: begin
                lo_d.oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_port_out <= WORD_ZERO;
            o_port_oe  <= 2'b00;
            o_blank_oe <= 1'b0;
            o_hsync_oe <= 1'b0;
            o_vsync_oe <= 1'b0;
        end else begin
            o_port_out <= {hi_d.dout, lo_d.dout};
            o_port_oe  <= {hi_d.oe, lo_d.oe};
            o_blank_oe <= sync_d.blank_oe;
            o_hsync_oe <= sync_d.hsync_oe;
            o_vsync_oe <= sync_d.vsync_oe;
        end
    end

    // ========================================
    // ramdac source and captured video
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ramdac_pixel   <= WORD_ZERO;
            o_ramdac_ext_src <= 1'b0;
        end else if (fc_in) begin
            o_ramdac_pixel   <= (mode_q == MODE_FC8) ? {BYTE_ZERO, lo_d.din}
                                                     : {hi_d.din, lo_d.din};
            o_ramdac_ext_src <= 1'b1;
        end else begin
            o_ramdac_pixel   <= i_int_pixel;
            o_ramdac_ext_src <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_video_word  <= WORD_ZERO;
            o_video_valid <= 1'b0;
        end else begin
            o_video_valid <= 1'b0;
            if (vclk_rise && !i_ext_display_clk_sel) begin
                case (mode_q)
                    MODE_VDEC: begin
                        o_video_word  <= {hi_d.din, lo_d.din};
                        o_video_valid <= 1'b1;
                    end
                    MODE_VMI, MODE_MPEG: begin
                        o_video_word  <= {BYTE_ZERO, lo_d.din};
                        o_video_valid <= 1'b1;
                    end
                    default: begin
                        o_video_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_host_rdata <= BYTE_ZERO;
        end else if ((mode_q == MODE_VMI || mode_q == MODE_MPEG) && !i_host_write) begin
            o_host_rdata <= hi_d.din;
        end
    end

    // ========================================
    // pixel clock pin
    pclk_src_t pclk_src;
    always_comb begin
        pclk_src = PCLK_FLOAT;
        if (i_test_mode) begin
            pclk_src = PCLK_SYNTH;
        end else begin
            case (mode_q)
                MODE_FC8:  pclk_src = dir_s ? PCLK_INTERNAL : PCLK_FLOAT;
                MODE_VAFC: pclk_src = PCLK_INTERNAL;
                MODE_FC16: pclk_src = dir_s ? PCLK_INTERNAL : PCLK_FLOAT;
                MODE_VMI:  pclk_src = PCLK_FLOAT;
                default:   pclk_src = PCLK_FLOAT;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pclk_pin_out    <= 1'b0;
            o_pclk_pin_oe     <= 1'b0;
            o_ramdac_clk_edge <= 1'b0;
            o_mode_reject     <= 1'b0;
        end else begin
            o_pclk_pin_oe     <= (pclk_src != PCLK_FLOAT);
            o_pclk_pin_out    <= (pclk_src == PCLK_SYNTH) ? i_clock_synth_clk
                               : (pclk_src == PCLK_INTERNAL) ? i_int_pixel_clk : 1'b0;
            // external pixel clock when selected, else pin in fc8 input
            o_ramdac_clk_edge <= i_ext_display_clk_sel ? vclk_rise
                               : (fc_in && mode_q == MODE_FC8) ? pclk_rise : 1'b0;
            o_mode_reject     <= reject_q;
        end
    end

    // ========================================
    // checks
    unconf_float_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_q == MODE_NONE && !i_test_mode) |=> (o_port_oe == 2'b00 && !o_pclk_pin_oe))
        else $error("port driven while unconfigured");
    fc_input_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        fc_in |=> (o_port_oe == 2'b00 && o_ramdac_ext_src))
        else $error("feature input not routed");
    lo_drive_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (fc_out && pix_normal) |=> o_port_oe[0])
        else $error("low byte not driven");
    vmi_lo_in_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_q == MODE_VMI) |=> !o_port_oe[0])
        else $error("vmi low byte driven");
    vafc_clk_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_q == MODE_VAFC && !i_test_mode) |=> o_pclk_pin_oe)
        else $error("vafc clock not driven");
    vmi_clk_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_q == MODE_VMI && !i_test_mode) |=> !o_pclk_pin_oe)
        else $error("vmi clock pin driven");
    ext_clk_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ext_display_clk_sel [*2] |-> (mode_q == MODE_FC8 || mode_q == MODE_NONE))
        else $error("bad mode with external clock");
    test_clk_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_test_mode |=> o_pclk_pin_oe)
        else $error("test clock not driven");
    dec_ignore_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (mode_q == MODE_VDEC) |=> (o_port_oe == 2'b00 && !o_blank_oe))
        else $error("decoder mode drives port");
endmodule
`default_nettype wire

// *** src/vport_pkg.sv ***
// package: modes, pin bundles and constants for the video feature port control
`default_nettype none
package vport_pkg;

    // port configuration selected by software
    typedef enum logic [2:0] {
        MODE_NONE,
        MODE_FC8,
        MODE_FC16,
        MODE_VAFC,
        MODE_VMI,
        MODE_VDEC,
        MODE_MPEG
    } port_mode_t;

    // pixel clock pin source selection
    typedef enum logic [1:0] {
        PCLK_FLOAT,
        PCLK_INTERNAL,
        PCLK_SYNTH
    } pclk_src_t;

    // one byte lane of the port: input, output, enable
    typedef struct packed {
        logic [7:0] din;
        logic [7:0] dout;
        logic       oe;
    } byte_lane_t;

    // pin enables for the sync and blank group
    typedef struct packed {
        logic blank_oe;
        logic hsync_oe;
        logic vsync_oe;
    } sync_oe_t;

    localparam int         SYNC_STAGES   = 2;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;
    localparam logic       PIX_OUT_NORMAL = 1'b0;

endpackage
`default_nettype wire

// *** src/vport_sync.sv ***
// two-flop synchroniser and edge finder for pins from outside the clock domain
`default_nettype none
module vport_sync
    import vport_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    // raw pins
    input  wire logic [WIDTH-1:0] i_async,
    // synchronised level and rising edge
    output logic      [WIDTH-1:0] o_sync,
    output logic      [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;

    // first stage is read only by the second
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign o_sync = sync_q;
    assign o_rise = sync_q & ~last_q;
endmodule
`default_nettype wire

// *** tb/feature_card_model.sv ***
// external card or decoder model at the far side of the port
`default_nettype none
module feature_card_model
    import vport_pkg::*;
(
    // clock for the float pattern
    input  wire logic        i_clk_sys,
    // bench controls
    input  wire logic        i_drive,
    input  wire logic        i_dir,
    input  wire logic        i_run,
    input  wire logic [15:0] i_data,
    // device pins
    input  wire logic [15:0] i_port_out,
    input  wire logic [1:0]  i_port_oe,
    input  wire logic        i_pclk_out,
    input  wire logic        i_pclk_oe,
    output logic             o_dir_pin,
    output logic      [15:0] o_port,
    output logic             o_pclk,
    output var logic         o_vclk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] flt_q = 16'h0000;
    // =========================================
    // video clock, still outside frames
    initial begin
        o_vclk = 1'b0;
        #7;
        forever #160 o_vclk = i_run ? ~o_vclk : 1'b0;
    end
    // released lanes change every cycle, never hold the last value
    always @(posedge i_clk_sys) flt_q <= ~flt_q;
    assign o_dir_pin = i_dir;
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            o_port[k*8 +: 8] = i_port_oe[k] ? i_port_out[k*8 +: 8]
                             : (i_drive ? i_data[k*8 +: 8] : flt_q[k*8 +: 8]);
        end
        o_pclk = i_pclk_oe ? i_pclk_out : o_vclk;
    end
endmodule
`default_nettype wire

// *** tb/test_video_feature_port_control.sv ***
// bench for the video feature port control with a card model
`default_nettype none
module test_video_feature_port_control
    import vport_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, mode_vld = 1'b0, ext = 1'b0, tst = 1'b0;
    logic        ctl = 1'b0, wr = 1'b0, drive = 1'b0, dir = 1'b0, run = 1'b0, synth = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic [1:0]  dpms = 2'h0;
    logic [15:0] cdata = 16'hA55A;
    logic        dir_pin, pclk_in, pclk_out, pclk_oe, vclk, b_oe, h_oe, v_oe;
    logic        ext_src, clk_edge, vvalid, reject;
    logic [15:0] port_in, port_out, ramdac_pix, vword;
    logic [7:0]  rdata, st;
    logic [1:0]  port_oe;
    logic [1:0]  pdiv = 2'h0;
    logic        pc_prev = 1'b0;
    int          n_fail = 0, num_checks = 0, n_vv = 0, n_ce = 0, n_pc = 0, dv, dc, dp;
    assign st = {reject, ext_src, b_oe, h_oe, v_oe, pclk_oe, port_oe};
    always #20 clk = ~clk;
    always @(posedge clk) synth <= ~synth;
    // internal pixel clock at a quarter rate, distinct from the synthesizer
    always @(posedge clk) pdiv <= pdiv + 2'h1;
    always @(posedge clk) begin
        if (vvalid === 1'b1) n_vv++;
        if (clk_edge === 1'b1) n_ce++;
        if (pclk_out !== pc_prev) n_pc++;
        pc_prev <= pclk_out;
    end
    video_feature_port_control i_video_feature_port_control (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_port_mode(mode), .i_mode_valid(mode_vld),
        .i_ext_display_clk_sel(ext), .i_test_mode(tst), .i_pixel_out_ctl(ctl),
        .i_blank_dpms(dpms), .i_hsync_dpms(dpms), .i_vsync_dpms(dpms),
        .i_host_write(wr), .i_host_wdata(8'h3C), .o_host_rdata(rdata),
        .i_int_pixel(16'h1E0F), .i_int_pixel_clk(pdiv[1]), .i_clock_synth_clk(synth),
        .i_ext_port_direction_pin(dir_pin), .i_port_in(port_in), .o_port_out(port_out),
        .o_port_oe(port_oe), .i_pclk_pin_in(pclk_in), .o_pclk_pin_out(pclk_out),
        .o_pclk_pin_oe(pclk_oe), .i_ext_video_clk_in(vclk), .o_blank_oe(b_oe),
        .o_hsync_oe(h_oe), .o_vsync_oe(v_oe), .o_ramdac_pixel(ramdac_pix),
        .o_ramdac_ext_src(ext_src), .o_ramdac_clk_edge(clk_edge), .o_video_word(vword),
        .o_video_valid(vvalid), .o_mode_reject(reject));
    feature_card_model i_feature_card_model (
        .i_clk_sys(clk), .i_drive(drive), .i_dir(dir), .i_run(run), .i_data(cdata),
        .i_port_out(port_out), .i_port_oe(port_oe), .i_pclk_out(pclk_out),
        .i_pclk_oe(pclk_oe), .o_dir_pin(dir_pin), .o_port(port_in), .o_pclk(pclk_in),
        .o_vclk(vclk));
    // =========================================
    // tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // flags: drive, dir, ctl, wr, ext, tst, run; status masked to what the mode fixes
    task automatic run_case(input port_mode_t m, input logic [6:0] f, input logic [1:0] p,
                            input logic [7:0] exp, input logic [7:0] msk);
        @(posedge clk);
        {drive, dir, ctl, wr, ext, tst, run} <= f;
        dpms <= p;
        mode <= m;
        mode_vld <= 1'b1;
        @(posedge clk);
        mode_vld <= 1'b0;
        repeat (10) @(posedge clk);
        #1 check(m.name(), {8'h00, st & msk}, {8'h00, exp & msk});
    endtask
    task automatic count_pulses;
        dv = n_vv;
        dc = n_ce;
        dp = n_pc;
        repeat (80) @(posedge clk);
        #1 dv = n_vv - dv;
        dc = n_ce - dc;
        dp = n_pc - dp;
    endtask
    // =========================================
    // sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        run_case(MODE_NONE, 7'h20, 2'h0, 8'h00, 8'h3F);
        run_case(MODE_FC8, 7'h41, 2'h0, 8'h40, 8'h7D);
        check("ramdac_lo", {8'h00, ramdac_pix[7:0]}, 16'h005A);
        count_pulses();
        check("pin_clk_edge_cnt", 16'(dc >= 9 && dc <= 11), 16'h0001);
        run_case(MODE_FC8, 7'h20, 2'h0, 8'h3D, 8'h7D);
        check("fc8_out", {8'h00, port_out[7:0]}, 16'h000F);
        run_case(MODE_FC8, 7'h30, 2'h0, 8'h3C, 8'h7D);
        run_case(MODE_FC8, 7'h20, 2'h3, 8'h05, 8'h7D);
        run_case(MODE_FC16, 7'h20, 2'h0, 8'h3F, 8'h7F);
        check("fc16_out", port_out, 16'h1E0F);
        run_case(MODE_FC16, 7'h40, 2'h0, 8'h40, 8'h7F);
        check("ramdac_word", ramdac_pix, 16'hA55A);
        run_case(MODE_VAFC, 7'h40, 2'h0, 8'h44, 8'h7F);
        count_pulses();
        check("pclk_vafc_cnt", 16'(dp >= 39 && dp <= 41), 16'h0001);
        run_case(MODE_VAFC, 7'h20, 2'h0, 8'h3F, 8'h7F);
        run_case(MODE_VMI, 7'h28, 2'h0, 8'h02, 8'h87);
        check("vmi_out", {8'h00, port_out[15:8]}, 16'h003C);
        run_case(MODE_VMI, 7'h60, 2'h0, 8'h00, 8'h87);
        check("vmi_rdata", {8'h00, rdata}, 16'h00A5);
        run_case(MODE_VDEC, 7'h61, 2'h0, 8'h18, 8'h9B);
        count_pulses();
        check("vvalid_cnt", 16'(dv >= 9 && dv <= 11), 16'h0001);
        check("video_word", vword, 16'hA55A);
        // new card data so the mpeg read cannot pass on a stale byte
        @(posedge clk) cdata <= 16'h5AC3;
        run_case(MODE_MPEG, 7'h41, 2'h0, 8'h18, 8'h9B);
        check("mpeg_rdata", {8'h00, rdata}, 16'h005A);
        check("mpeg_word", vword, 16'h00C3);
        run_case(MODE_MPEG, 7'h08, 2'h0, 8'h1A, 8'h9B);
        check("mpeg_out", {8'h00, port_out[15:8]}, 16'h003C);
        run_case(MODE_VAFC, 7'h24, 2'h0, 8'h80, 8'h87);
        run_case(MODE_FC8, 7'h45, 2'h0, 8'h40, 8'hC5);
        count_pulses();
        check("clk_edge_cnt", 16'(dc >= 9 && dc <= 11), 16'h0001);
        run_case(MODE_VMI, 7'h22, 2'h0, 8'h04, 8'h04);
        count_pulses();
        check("pclk_test_cnt", 16'(dp >= 79 && dp <= 81), 16'h0001);
        give_verdict();
    end
    // hang guard, about four times the expected run
    initial begin
        #100us;
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
